// ---- rtl/arc_cfg_regs.sv ----
// What the document requires of this block and its host
// RL1 - Writing code 1h to board_command resets software state and hardware.
// RL2 - The commanded reset acts on hardware exactly like power-on reset.
// RL3 - Commanded reset returns all settings, channel enables and paths, to default.
// RL4 - Commanded reset marks acquired sample memory contents invalid.
// RL5 - Commanded reset disables trigger and clock outputs.
// RL6 - Host issues a reset automatically on first driver load.
// RL7 - Programs should reset the board before any other configuration.
// RL8 - Channel enable bitmap: 1 enables channel 0, 2 channel 1; used next run.
// RL9 - Only masks 1h, 2h, 3h accepted; others rejected with an error.
// RL10 - Masks naming channels not installed are refused.
// RL11 - Channel enable reads return the programmed bitmap at any time.
// RL12 - Channel count register returns number of enabled channels.
// RL13 - Sample memory is shared among enabled channels only.
// RL14 - Path count register returns number of analog input paths.
// RL15 - Feature query path selector never changes any channel's active path.
// RL16 - Host sets feature query path before reading path features.
// RL17 - Each channel has its own read/write input path register.
// RL18 - Path value 0 selects buffered path, 1 the 50 ohm HF path.
// RL19 - Each channel path defaults to buffered after reset.
// RL20 - board_command is write-only; reset code acts once as a pulse.
`timescale 1ns/100ps
`default_nettype none

module arc_cfg_regs
    import arc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] installed_ch_mask,
    input wire logic run_start,
    input wire logic run_done,
    output logic [1:0] run_channel_mask,
    output logic ch0_path_sel,
    output logic ch1_path_sel,
    output logic mem_data_valid,
    output logic [MEM_LOG2:0] samples_per_channel,
    output logic trig_out_enable,
    output logic clk_out_enable,
    output logic board_reset_n
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] ch_mask;
        logic feat_path;
        logic ch0_path;
        logic ch1_path;
        logic [1:0] run_mask;
        logic mem_valid;
        logic trig_out_en;
        logic clk_out_en;
        logic [MEM_LOG2:0] per_ch;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic rst_req;
    } arc_cfg_st_t;

    localparam arc_cfg_st_t ST_RST = '{
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        ch_mask: CH_MASK_RST,
        feat_path: FEAT_PATH_RST,
        ch0_path: CH_PATH_RST,
        ch1_path: CH_PATH_RST,
        run_mask: CH_MASK_RST,
        mem_valid: 1'b0,
        trig_out_en: 1'b0,
        clk_out_en: 1'b0,
        per_ch: MEM_TOTAL_SAMPLES,
        strap_s1: 2'h0,
        strap_s2: 2'h0,
        rst_req: 1'b0
    };

    arc_cfg_st_t st_r;
    arc_cfg_st_t st_nxt;

    arc_rst_if rif ();

    arc_rst_gen u_rst_gen (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif.gen)
    );

    assign rif.req = st_r.rst_req;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] count_of(input logic [1:0] m);
        logic [31:0] c;
        c = 32'h0;
        c = c + {31'h0, m[0]};
        c = c + {31'h0, m[1]};
        return c;
    endfunction

    // A mask is legal only in the listed forms and only over fitted inputs
    function automatic logic mask_ok(input logic [31:0] v, input logic [1:0] inst);
        logic ok;
        ok = 1'b0;
        if (v == {30'h0, FIRST_INPUT_ENABLE_BIT} ||
            v == {30'h0, SECOND_INPUT_ENABLE_BIT} ||
            v == {30'h0, FIRST_INPUT_ENABLE_BIT | SECOND_INPUT_ENABLE_BIT}) begin
            ok = 1'b1; // RL9
        end
        if ((v[1:0] & ~inst) != 2'h0) begin
            ok = 1'b0; // RL10
        end
        return ok;
    endfunction

    function automatic logic path_ok(input logic [31:0] v);
        return v[31:1] == 31'h0;
    endfunction

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [IDX_W-1:0] idx;
    logic addr_aligned;
    logic access_ph;
    logic commit;

    assign idx = paddr[ADDR_W-1:2];
    assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[31:ADDR_W] == 15'h0);
    // One wait state keeps pready, prdata and pslverr straight from flops
    assign access_ph = psel && penable && !st_r.pready;
    assign commit = psel && penable && st_r.pready && pwrite && !st_r.pslverr;

    logic [31:0] rd_val;
    logic acc_err;

    always_comb begin
        rd_val = 32'h0000_0000;
        acc_err = 1'b0;
        if (!addr_aligned) begin
            acc_err = 1'b1;
        end else begin
            unique case (idx)
                IDX_BOARD_COMMAND: begin
                    rd_val = 32'h0000_0000; // RL20
                end
                IDX_INPUT_PATH_COUNT: begin
                    rd_val = INPUT_PATH_COUNT_VAL; // RL14
                    acc_err = pwrite;
                end
                IDX_FEATURE_QUERY_PATH: begin
                    rd_val = {31'h0, st_r.feat_path};
                    acc_err = pwrite && !path_ok(pwdata);
                end
                IDX_CHANNEL_ENABLE_MASK: begin
                    rd_val = {30'h0, st_r.ch_mask}; // RL11
                    acc_err = pwrite && !mask_ok(pwdata, st_r.strap_s2); // RL9 RL10
                end
                IDX_ENABLED_CHANNEL_COUNT: begin
                    rd_val = count_of(st_r.ch_mask); // RL12
                    acc_err = pwrite;
                end
                IDX_CH0_INPUT_PATH: begin
                    rd_val = {31'h0, st_r.ch0_path}; // RL17
                    acc_err = pwrite && !path_ok(pwdata);
                end
                IDX_CH1_INPUT_PATH: begin
                    rd_val = {31'h0, st_r.ch1_path}; // RL17
                    acc_err = pwrite && !path_ok(pwdata);
                end
                IDX_OUTPUT_CONTROL: begin
                    rd_val[OUTCTL_TRIG_BIT] = st_r.trig_out_en;
                    rd_val[OUTCTL_CLK_BIT] = st_r.clk_out_en;
                end
                IDX_BOARD_STATUS: begin
                    rd_val[STAT_MEM_VALID_BIT] = st_r.mem_valid;
                    rd_val[STAT_RST_BUSY_BIT] = rif.active;
                    rd_val[STAT_INSTALLED_LSB +: 2] = st_r.strap_s2;
                    acc_err = pwrite;
                end
                default: begin
                    acc_err = 1'b1;
                end
            endcase
        end
        // Writes while the board is held in reset would be lost anyway
        if (pwrite && rif.active) begin
            acc_err = 1'b1;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_req = 1'b0; // RL20
        st_nxt.strap_s1 = installed_ch_mask;
        st_nxt.strap_s2 = st_r.strap_s1;

        // Bus answer
        st_nxt.pready = access_ph;
        if (access_ph) begin
            st_nxt.pslverr = acc_err; // RL9
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
        end else begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata = 32'h0000_0000;
        end

        // Writes take effect on the edge that completes the transfer
        if (commit) begin
            unique case (idx)
                IDX_BOARD_COMMAND: begin
                    if (pwdata == FULL_BOARD_RESET_CODE) begin
                        st_nxt.rst_req = 1'b1; // RL1 RL20
                    end
                end
                IDX_FEATURE_QUERY_PATH: begin
                    st_nxt.feat_path = pwdata[0]; // RL15
                end
                IDX_CHANNEL_ENABLE_MASK: begin
                    st_nxt.ch_mask = pwdata[1:0]; // RL8
                end
                IDX_CH0_INPUT_PATH: begin
                    st_nxt.ch0_path = pwdata[0]; // RL18
                end
                IDX_CH1_INPUT_PATH: begin
                    st_nxt.ch1_path = pwdata[0]; // RL18
                end
                IDX_OUTPUT_CONTROL: begin
                    st_nxt.trig_out_en = pwdata[OUTCTL_TRIG_BIT];
                    st_nxt.clk_out_en = pwdata[OUTCTL_CLK_BIT];
                end
                default: begin
                end
            endcase
        end

        // Acquisition run: mask and memory split are frozen at start
        if (run_start) begin
            st_nxt.run_mask = st_r.ch_mask; // RL8
            st_nxt.mem_valid = 1'b0;
            if (count_of(st_r.ch_mask) == 32'h2) begin
                st_nxt.per_ch = MEM_TOTAL_SAMPLES >> 1; // RL13
            end else begin
                st_nxt.per_ch = MEM_TOTAL_SAMPLES; // RL13
            end
        end else if (run_done) begin
            st_nxt.mem_valid = 1'b1;
        end

        // Commanded reset holds every setting at its power-on value
        if (st_r.rst_req || rif.active) begin
            st_nxt.ch_mask = CH_MASK_RST; // RL3
            st_nxt.feat_path = FEAT_PATH_RST; // RL3
            st_nxt.ch0_path = CH_PATH_RST; // RL19
            st_nxt.ch1_path = CH_PATH_RST; // RL19
            st_nxt.run_mask = CH_MASK_RST; // RL3
            st_nxt.per_ch = MEM_TOTAL_SAMPLES; // RL2
            st_nxt.mem_valid = 1'b0; // RL4
            st_nxt.trig_out_en = 1'b0; // RL5
            st_nxt.clk_out_en = 1'b0; // RL5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST; // RL19
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign run_channel_mask = st_r.run_mask;
    // Feature path is never routed here, so queries cannot move inputs
    assign ch0_path_sel = st_r.ch0_path; // RL15
    assign ch1_path_sel = st_r.ch1_path; // RL15
    assign mem_data_valid = st_r.mem_valid;
    assign samples_per_channel = st_r.per_ch;
    assign trig_out_enable = st_r.trig_out_en;
    assign clk_out_enable = st_r.clk_out_en;
    assign board_reset_n = rif.board_rst_n; // RL2

endmodule

`default_nettype wire

// ---- rtl/arc_pkg.sv ----
package arc_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 17;
    localparam int IDX_W = 15;

    // ************************************************************
    // Register indices; byte address is four times the index
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_BOARD_COMMAND = 15'h0064;
    localparam logic [IDX_W-1:0] IDX_INPUT_PATH_COUNT = 15'h0c30;
    localparam logic [IDX_W-1:0] IDX_FEATURE_QUERY_PATH = 15'h0c31;
    localparam logic [IDX_W-1:0] IDX_CHANNEL_ENABLE_MASK = 15'h2af8;
    localparam logic [IDX_W-1:0] IDX_ENABLED_CHANNEL_COUNT = 15'h2af9;
    localparam logic [IDX_W-1:0] IDX_CH0_INPUT_PATH = 15'h758a;
    localparam logic [IDX_W-1:0] IDX_CH1_INPUT_PATH = 15'h75ee;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_CONTROL = 15'h0066;
    localparam logic [IDX_W-1:0] IDX_BOARD_STATUS = 15'h0067;

    // ************************************************************
    // Codes, fields and reset values
    // ************************************************************
    localparam logic [31:0] FULL_BOARD_RESET_CODE = 32'h0000_0001;
    localparam logic [1:0] FIRST_INPUT_ENABLE_BIT = 2'h1;
    localparam logic [1:0] SECOND_INPUT_ENABLE_BIT = 2'h2;
    localparam logic [31:0] INPUT_PATH_COUNT_VAL = 32'h0000_0002;
    localparam logic PATH_BUFFERED = 1'h0;
    localparam logic PATH_HF_50OHM = 1'h1;
    localparam int OUTCTL_TRIG_BIT = 0;
    localparam int OUTCTL_CLK_BIT = 1;
    localparam int STAT_MEM_VALID_BIT = 0;
    localparam int STAT_RST_BUSY_BIT = 1;
    localparam int STAT_INSTALLED_LSB = 4;
    localparam logic [1:0] CH_MASK_RST = 2'h1;
    localparam logic FEAT_PATH_RST = 1'h0;
    localparam logic CH_PATH_RST = 1'h0;

    // ************************************************************
    // Sample memory and timing
    // ************************************************************
    localparam int MEM_LOG2 = 24;
    localparam logic [MEM_LOG2:0] MEM_TOTAL_SAMPLES = 25'h100_0000;
    localparam int CLK_MHZ = 200;
    localparam int RST_PULSE_NS = 80;
    localparam int RST_PULSE_CYC_I = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] RST_PULSE_CYC = 8'(RST_PULSE_CYC_I);

endpackage

// ---- rtl/arc_rst_gen.sv ----
`timescale 1ns/100ps
`default_nettype none

module arc_rst_gen
    import arc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    arc_rst_if.gen rif
);

    typedef struct packed {
        logic [7:0] cnt;
        logic active;
        logic board_rst_n;
    } arc_gen_st_t;

    arc_gen_st_t st_r;
    arc_gen_st_t st_nxt;

    // ************************************************************
    // Reset pulse stretcher
    // ************************************************************
    // A fixed-width pulse so the rest of the board sees the same
    // reset it gets at power-on, not a single-cycle glitch
    always_comb begin
        st_nxt = st_r;
        if (st_r.active) begin
            if (st_r.cnt == 8'h00) begin
                st_nxt.active = 1'b0;
                st_nxt.board_rst_n = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 8'h01;
            end
        end else if (rif.req) begin
            st_nxt.cnt = RST_PULSE_CYC - 8'h01; // RL2
            st_nxt.active = 1'b1; // RL1
            st_nxt.board_rst_n = 1'b0; // RL2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{cnt: 8'h00, active: 1'b0, board_rst_n: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.active = st_r.active;
    assign rif.board_rst_n = st_r.board_rst_n;

endmodule

`default_nettype wire

// ---- rtl/arc_rst_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface arc_rst_if;
    logic req;
    logic active;
    logic board_rst_n;

    modport ctl (output req, input active, input board_rst_n);
    modport gen (input req, output active, output board_rst_n);
endinterface

`default_nettype wire

// ---- sim/acq_reset_channel_path_config_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module acq_reset_channel_path_config_test
    import arc_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic run_start = 1'h0, run_done = 1'h0;
    logic [1:0] installed_ch_mask = 2'h3;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed = 32'h120b;
    logic pready, pslverr, ch0_path_sel, ch1_path_sel, mem_data_valid;
    logic trig_out_enable, clk_out_enable, board_reset_n;
    logic [1:0] run_channel_mask, em;
    logic [MEM_LOG2:0] samples_per_channel;
    logic [31:0] m;
    int bad_count = 0, cmp_count = 0;

    arc_cfg_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .installed_ch_mask(installed_ch_mask), .run_start(run_start),
        .run_done(run_done), .run_channel_mask(run_channel_mask),
        .ch0_path_sel(ch0_path_sel), .ch1_path_sel(ch1_path_sel),
        .mem_data_valid(mem_data_valid), .samples_per_channel(samples_per_channel),
        .trig_out_enable(trig_out_enable), .clk_out_enable(clk_out_enable),
        .board_reset_n(board_reset_n));

    always #2.5 pclk = ~pclk;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ba(input logic [IDX_W-1:0] i);
        return {15'h0, i, 2'h0};
    endfunction
    function automatic logic [31:0] cnt(input logic [1:0] k);
        return {31'h0, k[0]} + {31'h0, k[1]};
    endfunction
    // Status word with both channels fitted
    function automatic logic [31:0] stat(input logic mv, input logic busy);
        return (32'h3 << STAT_INSTALLED_LSB) | (32'(busy) << STAT_RST_BUSY_BIT) |
            (32'(mv) << STAT_MEM_VALID_BIT);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // Transfer leaves one idle edge so psel is never driven twice in a step
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) bad_count++;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, d, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
        chk(32'(e), 32'(ee));
    endtask
    task automatic rd(input logic [31:0] a, x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        #100000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        wr(ba(IDX_BOARD_COMMAND), FULL_BOARD_RESET_CODE, 1'h0);
        rd(ba(IDX_BOARD_STATUS), stat(1'h0, 1'h1));
        repeat (20) @(posedge pclk);
        rd(ba(IDX_CHANNEL_ENABLE_MASK), 32'h1);
        rd(ba(IDX_ENABLED_CHANNEL_COUNT), 32'h1);
        rd(ba(IDX_INPUT_PATH_COUNT), INPUT_PATH_COUNT_VAL);
        rd(ba(IDX_CH0_INPUT_PATH), 32'h0);
        rd(ba(IDX_CH1_INPUT_PATH), 32'h0);
        rd(ba(IDX_BOARD_COMMAND), 32'h0);
        wr(ba(IDX_INPUT_PATH_COUNT), 32'h5, 1'h1);
        wr(ba(IDX_ENABLED_CHANNEL_COUNT), 32'h1, 1'h1);
        wr(32'h4, 32'h1, 1'h1);
        $display("test reset values done");
        em = 2'h1;
        for (int i = 0; i < 14; i++) begin
            m = (i < 8) ? 32'(i) : ((i[0]) ? (xs() & 32'h3) : xs());
            wr(ba(IDX_CHANNEL_ENABLE_MASK), m, !(m inside {32'h1, 32'h2, 32'h3}));
            if (m inside {32'h1, 32'h2, 32'h3}) em = m[1:0];
            rd(ba(IDX_CHANNEL_ENABLE_MASK), {30'h0, em});
            rd(ba(IDX_ENABLED_CHANNEL_COUNT), cnt(em));
        end
        $display("test channel masks done");
        installed_ch_mask <= 2'h1;
        repeat (4) @(posedge pclk);
        wr(ba(IDX_CHANNEL_ENABLE_MASK), 32'h2, 1'h1);
        wr(ba(IDX_CHANNEL_ENABLE_MASK), 32'h3, 1'h1);
        wr(ba(IDX_CHANNEL_ENABLE_MASK), 32'h1, 1'h0);
        installed_ch_mask <= 2'h3;
        repeat (4) @(posedge pclk);
        $display("test fitted channels done");
        wr(ba(IDX_CH0_INPUT_PATH), 32'h1, 1'h0);
        wr(ba(IDX_CH1_INPUT_PATH), 32'h2, 1'h1);
        rd(ba(IDX_CH0_INPUT_PATH), 32'h1);
        rd(ba(IDX_CH1_INPUT_PATH), 32'h0);
        wr(ba(IDX_FEATURE_QUERY_PATH), 32'h1, 1'h0);
        wr(ba(IDX_FEATURE_QUERY_PATH), 32'h2, 1'h1);
        rd(ba(IDX_FEATURE_QUERY_PATH), 32'h1);
        chk(32'({ch0_path_sel, ch1_path_sel}), 32'h2);
        $display("test input paths done");
        wr(ba(IDX_CHANNEL_ENABLE_MASK), 32'h3, 1'h0);
        wr(ba(IDX_OUTPUT_CONTROL), 32'h3, 1'h0);
        chk(32'(run_channel_mask), 32'h1);
        run_start <= 1'h1;
        @(posedge pclk);
        run_start <= 1'h0;
        run_done <= 1'h1;
        @(posedge pclk);
        run_done <= 1'h0;
        @(posedge pclk);
        chk(32'(run_channel_mask), 32'h3);
        chk(32'(samples_per_channel), 32'(MEM_TOTAL_SAMPLES >> 1));
        chk(32'({mem_data_valid, trig_out_enable, clk_out_enable}), 32'h7);
        wr(ba(IDX_BOARD_COMMAND), 32'h2, 1'h0);
        rd(ba(IDX_BOARD_STATUS), stat(1'h1, 1'h0));
        chk(32'({board_reset_n, mem_data_valid}), 32'h3);
        $display("test run done");
        wr(ba(IDX_BOARD_COMMAND), FULL_BOARD_RESET_CODE, 1'h0);
        wr(ba(IDX_CH1_INPUT_PATH), 32'h1, 1'h1);
        chk(32'(board_reset_n), 32'h0);
        repeat (20) @(posedge pclk);
        // Mask, paths, memory valid, output enables, reset line, in that order
        chk(32'({run_channel_mask, ch0_path_sel, ch1_path_sel, mem_data_valid,
            trig_out_enable, clk_out_enable, board_reset_n}), 32'h41);
        chk(32'(samples_per_channel), 32'(MEM_TOTAL_SAMPLES));
        rd(ba(IDX_CHANNEL_ENABLE_MASK), 32'h1);
        rd(ba(IDX_CH0_INPUT_PATH), 32'h0);
        rd(ba(IDX_OUTPUT_CONTROL), 32'h0);
        rd(ba(IDX_FEATURE_QUERY_PATH), 32'h0);
        rd(ba(IDX_BOARD_STATUS), stat(1'h0, 1'h0));
        $display("test commanded reset done");
        conclude();
    end
endmodule

`default_nettype wire

// ---- sim/arc_cfg_regs_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module arc_cfg_regs_sva
    import arc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] run_channel_mask,
    input wire logic ch0_path_sel,
    input wire logic ch1_path_sel,
    input wire logic mem_data_valid,
    input wire logic [MEM_LOG2:0] samples_per_channel,
    input wire logic trig_out_enable,
    input wire logic clk_out_enable,
    input wire logic board_reset_n
);
    // ************************************************************
    // Bus, reset and memory split checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Only an accepted code write starts the reset; a refused one must not
    sequence cmd_wr;
        psel && penable && pready && pwrite && !pslverr
            && paddr == 32'h0000_0190 && pwdata == FULL_BOARD_RESET_CODE;
    endsequence
    sequence held_low;
        !board_reset_n [*8];
    endsequence

    ack_delay_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready not given one cycle into access");
    ack_single_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    path_count_a: assert property (pready && !pwrite && paddr == 32'h0000_30c0 |->
        prdata == INPUT_PATH_COUNT_VAL && !pslverr) else $error("path count wrong");
    mask_refuse_a: assert property (pready && pwrite && paddr == 32'h0000_abe0 &&
        !(pwdata inside {32'h1, 32'h2, 32'h3}) |-> pslverr) else $error("bad mask taken");
    cmd_defaults_a: assert property (cmd_wr |-> ##2 (run_channel_mask == CH_MASK_RST &&
        ch0_path_sel == CH_PATH_RST && ch1_path_sel == CH_PATH_RST && !mem_data_valid
        && !trig_out_enable && !clk_out_enable)) else $error("settings not defaulted");
    cmd_pulse_a: assert property (cmd_wr |-> ##3 held_low)
        else $error("board reset pulse too short");
    cmd_release_a: assert property (cmd_wr |-> ##[17:22] board_reset_n)
        else $error("board reset not released");
    mem_split_a: assert property (samples_per_channel == ((run_channel_mask == 2'h3) ?
        (MEM_TOTAL_SAMPLES >> 1) : MEM_TOTAL_SAMPLES)) else $error("memory split wrong");
endmodule

bind arc_cfg_regs arc_cfg_regs_sva i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_channel_mask(run_channel_mask), .ch0_path_sel(ch0_path_sel),
    .ch1_path_sel(ch1_path_sel), .mem_data_valid(mem_data_valid),
    .samples_per_channel(samples_per_channel), .trig_out_enable(trig_out_enable),
    .clk_out_enable(clk_out_enable), .board_reset_n(board_reset_n)
);

`default_nettype wire
